// >>> hdl/core_regulator_pkg.sv
/*
  Constants shared by the core regulator power sequencer.
  Assumes a 100 MHz reference clock.
*/
package core_regulator_pkg;
  localparam int CLK_PERIOD_NS     = 10;
  localparam int MODE_SAMPLE_NS    = 10000;
  localparam int BOOT_QUAL_NS      = 73000;
  localparam int CPU_PG_DELAY_NS   = 4700000;
  localparam int GFX_PG_DELAY_NS   = 4770000;
  localparam int SLEEP_MASK_NS     = 73000;
  localparam int SOFT_START_NS     = 1000000;
  localparam int MODE_SAMPLE_CYC   = MODE_SAMPLE_NS / CLK_PERIOD_NS;
  localparam int BOOT_QUAL_CYC     = (BOOT_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CPU_PG_DELAY_CYC  = (CPU_PG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GFX_PG_DELAY_CYC  = (GFX_PG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_MASK_CYC    = (SLEEP_MASK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SOFT_START_CYC    = SOFT_START_NS / CLK_PERIOD_NS;
  localparam int OC_TRIP_CYCLES    = 15;
  localparam int CNT_W             = 20;
  // Ramp current selection codes
  localparam logic [1:0] RAMP_OFF  = 2'h0;
  localparam logic [1:0] RAMP_20UA = 2'h1;
  localparam logic [1:0] RAMP_50UA = 2'h2;
  localparam logic [1:0] RAMP_100UA = 2'h3;
  typedef enum logic [3:0] {
    ST_OFF, ST_SAMPLE, ST_CPU_RAMP, ST_CPU_QUAL, ST_CPU_PGWAIT,
    ST_GFX_RAMP, ST_RUN, ST_SOFT_DOWN, ST_SHUTDOWN, ST_FAULT
  } seq_state_e;
endpackage

// >>> hdl/core_regulator_power_sequencer.sv
/*
  Sequencing and protection state logic of a single-phase core regulator.
  Assumes analog comparators arrive as asynchronous boolean levels and
  a free-running 100 MHz reference clock; i_rstn covers supply power-on.
*/
// Overview of operation
// - Regulator-on with enable pin high selects CPU mode, low selects render
// - Clock-enable pin is sampled within 10 us of regulator-on rising
// - CPU mode soft-starts toward boot voltage, done within 1 ms
// - CPU mode drives clock-enable low after 73 us above boot minus 0.1V
// - CPU mode asserts power-good 4.7 ms after clock-enable driven low
// - Render mode soft-starts toward DAC target within 1 ms
// - Render power-good after 4.77 ms above DAC minus 100mV
// - Deep-sleep request ignored until power-good asserted
// - Undervoltage masked during power-up while below the mode threshold
// - Ramp current: 20 start/stop, 50 transitions, 100 render ring-free up
// - Regulator-on low drops power-good at once and soft-ramps down
// - Below 200mV in power-down: gates off, discharge on, analog off
// - Deep-sleep rise masks UV, OC and OV faults for 73 us
// - Ring-free mode while deep-sleep is 1, continuous conduction otherwise
// - Over-limit inductor current holds the high-side gate off
// - Fifteen consecutive limited switching cycles trip overcurrent shutdown
// - Overcurrent fault latched until regulator-on or supply cycles
`timescale 1ns/1ps
`default_nettype none
module core_regulator_power_sequencer
  import core_regulator_pkg::*;
#(
  parameter int MODE_SAMPLE = MODE_SAMPLE_CYC,
  parameter int BOOT_QUAL   = BOOT_QUAL_CYC,
  parameter int CPU_PG      = CPU_PG_DELAY_CYC,
  parameter int GFX_PG      = GFX_PG_DELAY_CYC,
  parameter int SLEEP_MASK  = SLEEP_MASK_CYC,
  parameter int OC_TRIP     = OC_TRIP_CYCLES
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_regulator_on,
  input  wire logic       i_deep_sleep_request,
  input  wire logic       i_core_clock_enable_n,
  input  wire logic       i_sense_above_boot,
  input  wire logic       i_sense_above_dac,
  input  wire logic       i_sense_below_200mv,
  input  wire logic       i_undervoltage,
  input  wire logic       i_overvoltage,
  input  wire logic       i_over_current_limit,
  input  wire logic       i_switch_cycle,
  input  wire logic       i_voltage_id_up,
  input  wire logic       i_voltage_id_change,
  output logic            o_core_clock_enable_n_out,
  output logic            o_core_clock_enable_n_oe,
  output logic            o_power_good,
  output logic            o_cpu_mode,
  output logic [1:0]      o_ramp_current_sel,
  output logic            o_ramp_up,
  output logic            o_target_boot,
  output logic            o_high_side_gate_en,
  output logic            o_low_side_gate_en,
  output logic            o_discharge_en,
  output logic            o_analog_en,
  output logic            o_ring_free_mode,
  output logic            o_undervoltage_mask,
  output logic            o_fault_mask,
  output logic            o_overcurrent_fault,
  output logic            o_undervoltage_fault,
  output logic            o_overvoltage_fault
);
  initial begin
    if (MODE_SAMPLE < 4 || BOOT_QUAL < 1 || CPU_PG < 1 || GFX_PG < 1 ||
        SLEEP_MASK < 1 || OC_TRIP < 1 || CPU_PG >= (1 << CNT_W) ||
        GFX_PG >= (1 << CNT_W) || OC_TRIP > 255)
      $error("core_regulator_power_sequencer: unsupported parameter");
  end

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  localparam int NSYNC = 12;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] syn;
  assign raw_in = {i_regulator_on, i_deep_sleep_request, i_core_clock_enable_n,
                   i_sense_above_boot, i_sense_above_dac, i_sense_below_200mv,
                   i_undervoltage, i_overvoltage, i_over_current_limit,
                   i_switch_cycle, i_voltage_id_up, i_voltage_id_change};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      input_sync #(.RESET_VALUE(1'b0)) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_rstn    (i_rstn),
        .i_async   (raw_in[g]),
        .o_level   (syn[g])
      );
    end
  endgenerate

  logic von, dsr, cken_pin, above_boot, above_dac, below_200, uv, ov, oc, sw, id_up, id_chg;
  assign {von, dsr, cken_pin, above_boot, above_dac, below_200,
          uv, ov, oc, sw, id_up, id_chg} = syn;

  logic von_d, dsr_d, sw_d;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      von_d <= 1'b0;
      dsr_d <= 1'b0;
      sw_d  <= 1'b0;
    end else begin
      von_d <= von;
      dsr_d <= dsr;
      sw_d  <= sw;
    end
  end
  logic von_rise, dsr_rise, sw_rise;
  assign von_rise = von & ~von_d;
  assign dsr_rise = dsr & ~dsr_d;
  assign sw_rise  = sw & ~sw_d;

  // ==========================================================
  // Sequencer
  // ==========================================================
  seq_state_e state;
  logic [CNT_W-1:0] cnt;
  logic cpu_mode;
  logic oc_fault, uv_fault, ov_fault;
  logic any_fault;
  assign any_fault = oc_fault | uv_fault | ov_fault;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      state    <= ST_OFF;
      cnt      <= '0;
      cpu_mode <= 1'b0;
    end else if (!von && state != ST_OFF && state != ST_SHUTDOWN &&
                 state != ST_SOFT_DOWN && state != ST_FAULT) begin
      state <= ST_SOFT_DOWN;
      cnt   <= '0;
    end else begin
      case (state)
        ST_OFF: begin
          cnt <= '0;
          if (von_rise) state <= ST_SAMPLE;
        end
        ST_SAMPLE: begin
          cnt <= cnt + 1'b1;
          // Decide mode before the 10 us window closes
          if (cnt == CNT_W'(MODE_SAMPLE - 2)) begin
            cpu_mode <= cken_pin;
            state    <= cken_pin ? ST_CPU_RAMP : ST_GFX_RAMP;
            cnt      <= '0;
          end
        end
        ST_CPU_RAMP: begin
          if (any_fault) state <= ST_FAULT;
          else if (above_boot) begin
            cnt <= cnt + 1'b1;
            if (cnt == CNT_W'(BOOT_QUAL - 1)) begin
              state <= ST_CPU_PGWAIT;
              cnt   <= '0;
            end
          end else cnt <= '0;
        end
        ST_CPU_PGWAIT: begin
          cnt <= cnt + 1'b1;
          if (any_fault) state <= ST_FAULT;
          else if (cnt == CNT_W'(CPU_PG - 1)) begin
            state <= ST_RUN;
            cnt   <= '0;
          end
        end
        ST_GFX_RAMP: begin
          if (any_fault) state <= ST_FAULT;
          else if (above_dac) begin
            cnt <= cnt + 1'b1;
            if (cnt == CNT_W'(GFX_PG - 1)) begin
              state <= ST_RUN;
              cnt   <= '0;
            end
          end else cnt <= '0;
        end
        ST_RUN: if (any_fault) state <= ST_FAULT;
        ST_SOFT_DOWN: begin
          if (von_rise) state <= ST_SAMPLE;
          else if (below_200) state <= ST_SHUTDOWN;
          cnt <= '0;
        end
        ST_SHUTDOWN: begin
          cnt <= '0;
          if (von_rise) state <= ST_SAMPLE;
        end
        ST_FAULT: begin
          cnt <= '0;
          if (von_rise) state <= ST_SAMPLE;
        end
        default: state <= ST_OFF;
      endcase
    end
  end

  // ==========================================================
  // Deep sleep and fault masking
  // ==========================================================
  logic [CNT_W-1:0] mask_cnt;
  logic sleep_valid;
  assign sleep_valid = (state == ST_RUN) & dsr;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      mask_cnt <= '0;
    end else if (state == ST_RUN && dsr_rise) begin
      mask_cnt <= CNT_W'(SLEEP_MASK);
    end else if (mask_cnt != '0) begin
      mask_cnt <= mask_cnt - 1'b1;
    end
  end

  logic fault_mask, uv_mask;
  assign fault_mask = (mask_cnt != '0);
  assign uv_mask = fault_mask | (state == ST_SAMPLE) |
                   (state == ST_CPU_RAMP && !above_boot) |
                   (state == ST_GFX_RAMP && !above_dac) |
                   (state == ST_OFF) | (state == ST_SOFT_DOWN) | (state == ST_SHUTDOWN);

  // ==========================================================
  // Over-current limit counting and fault latches
  // ==========================================================
  logic [7:0] oc_cycles;
  logic active;
  assign active = (state == ST_CPU_RAMP) | (state == ST_CPU_PGWAIT) |
                  (state == ST_GFX_RAMP) | (state == ST_RUN);

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || von_rise) begin
      oc_cycles <= 8'h00;
    end else if (sw_rise) begin
      oc_cycles <= (oc && !fault_mask && active) ? oc_cycles + 8'h01 : 8'h00;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || von_rise) begin
      oc_fault <= 1'b0;
      uv_fault <= 1'b0;
      ov_fault <= 1'b0;
    end else begin
      if (oc_cycles >= 8'(OC_TRIP)) oc_fault <= 1'b1;
      if (active && uv && !uv_mask) uv_fault <= 1'b1;
      if (active && ov && !fault_mask) ov_fault <= 1'b1;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  logic [1:0] next_ramp;
  always_comb begin
    next_ramp = RAMP_50UA;
    if (state == ST_OFF || state == ST_SHUTDOWN || state == ST_FAULT)
      next_ramp = RAMP_OFF;
    else if (state != ST_RUN && state != ST_CPU_PGWAIT)
      next_ramp = RAMP_20UA;
    else if (!cpu_mode && sleep_valid && id_up && id_chg)
      next_ramp = RAMP_100UA;
  end

  logic gates_on;
  assign gates_on = active & ~any_fault | (state == ST_SOFT_DOWN);

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_power_good              <= 1'b0;
      o_core_clock_enable_n_oe  <= 1'b0;
      o_ramp_current_sel        <= RAMP_OFF;
      o_ramp_up                 <= 1'b0;
      o_target_boot             <= 1'b0;
      o_high_side_gate_en       <= 1'b0;
      o_low_side_gate_en        <= 1'b0;
      o_discharge_en            <= 1'b0;
      o_analog_en               <= 1'b0;
      o_ring_free_mode          <= 1'b0;
      o_cpu_mode                <= 1'b0;
    end else begin
      o_power_good <= (state == ST_RUN) & von;
      o_core_clock_enable_n_oe <= cpu_mode &
        (state == ST_CPU_PGWAIT || state == ST_RUN);
      o_ramp_current_sel  <= next_ramp;
      o_ramp_up           <= active;
      o_target_boot       <= (state == ST_CPU_RAMP);
      o_high_side_gate_en <= gates_on & ~oc;
      o_low_side_gate_en  <= gates_on;
      o_discharge_en      <= (state == ST_SHUTDOWN) | any_fault;
      o_analog_en         <= (state != ST_OFF) & (state != ST_SHUTDOWN);
      o_ring_free_mode    <= sleep_valid;
      o_cpu_mode          <= cpu_mode;
    end
  end

  assign o_core_clock_enable_n_out = 1'b0;
  assign o_undervoltage_mask  = uv_mask;
  assign o_fault_mask         = fault_mask;
  assign o_overcurrent_fault  = oc_fault;
  assign o_undervoltage_fault = uv_fault;
  assign o_overvoltage_fault  = ov_fault;

  // ==========================================================
  // Checks
  // ==========================================================
  sequence s_pg_rise;
    !o_power_good ##1 o_power_good;
  endsequence

  chk_pg_needs_run: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    s_pg_rise |-> $past(state == ST_RUN))
    else $error("power good rose outside run");
  chk_pg_drop_off: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (o_power_good && !von) |=> ##1 !o_power_good)
    else $error("power good not dropped after regulator off");
  chk_sleep_mask: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (state == ST_RUN && dsr_rise) |=> fault_mask [*8])
    else $error("fault mask not held after sleep entry");
  chk_ring_free_gate: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_ring_free_mode |-> $past(state == ST_RUN))
    else $error("ring free mode before power good");
  chk_oc_latch: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (oc_fault && !von_rise) |=> oc_fault)
    else $error("overcurrent fault released");
  chk_hs_off_oc: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    oc |=> !o_high_side_gate_en)
    else $error("high side on during current limit");
  chk_shutdown_gate: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (state == ST_SHUTDOWN) |=> (!o_low_side_gate_en && o_discharge_en))
    else $error("gates active in shutdown");
  chk_oc_trip: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (oc_cycles >= 8'(OC_TRIP) && !von_rise) |=> oc_fault ##1 !o_low_side_gate_en)
    else $error("overcurrent not tripped");
  chk_soft_ramp: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (state == ST_SOFT_DOWN) |=> (o_ramp_current_sel == RAMP_20UA))
    else $error("wrong ramp current in soft shutdown");
endmodule // core_regulator_power_sequencer
`default_nettype wire

// >>> hdl/input_sync.sv
/*
  Three-flop synchroniser with agreement filter for one asynchronous level.
  Assumes the input may change at any time relative to i_ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
  parameter logic RESET_VALUE = 1'b0
) (
  input  wire logic i_ref_clk,
  input  wire logic i_rstn,
  input  wire logic i_async,
  output logic      o_level
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      s1 <= RESET_VALUE;
      s2 <= RESET_VALUE;
      s3 <= RESET_VALUE;
    end else begin
      s1 <= i_async;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Accept a change once the second and third stages agree
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_level <= RESET_VALUE;
    end else if (s2 == s3) begin
      o_level <= s3;
    end
  end
endmodule // input_sync
`default_nettype wire

// >>> testbench/core_regulator_partner_model.sv
/*
  Board-side model: output stage level, its comparators, switching clock, strap pin.
  Assumes the sequencer drives ramp, discharge and pin-pull controls on i_ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module core_regulator_partner_model
  import core_regulator_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_ramp_up,
  input  wire logic [1:0] i_ramp_current_sel,
  input  wire logic       i_power_good,
  input  wire logic       i_discharge_en,
  input  wire logic       i_pin_out,
  input  wire logic       i_pin_oe,
  input  wire logic       i_strap_high,
  output logic            o_pin_level,
  output logic            o_sense_above_boot,
  output logic            o_sense_above_dac,
  output logic            o_sense_below_200mv,
  output logic            o_switch_cycle
);
  logic [5:0] level;
  logic [1:0] sw_div;
  // ==========================================================
  // Open-drain strap: pulled low by the device, else the strap
  assign o_pin_level = i_pin_oe ? i_pin_out : i_strap_high;
  // ==========================================================
  // Output level follows the soft reference
  always @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      level <= 6'h00;
    end else if (i_ramp_up && level < 6'h3c) begin
      level <= level + 6'h01;
    end else if ((i_discharge_en || (!i_ramp_up && !i_power_good && i_ramp_current_sel != RAMP_OFF))
                 && level != 6'h00) begin
      level <= level - 6'h01;
    end
  end
  assign o_sense_above_boot  = level > 6'h28;
  assign o_sense_above_dac   = level > 6'h28;
  assign o_sense_below_200mv = level < 6'h05;
  // ==========================================================
  // Free-running switching cycles, one rise each 8 clocks
  always @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      sw_div         <= 2'h0;
      o_switch_cycle <= 1'b0;
    end else begin
      sw_div <= sw_div + 2'h1;
      if (sw_div == 2'h3) begin
        o_switch_cycle <= !o_switch_cycle;
      end
    end
  end
endmodule // core_regulator_partner_model
`default_nettype wire

// >>> testbench/testbench.sv
/*
  Self-checking bench for the core regulator power sequencer.
  Assumes shortened interval parameters and the board model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
  import core_regulator_pkg::*;
;
  localparam int MS = 8, BQ = 5, CPG = 20, GPG = 20, SM = 10, OCT = 15;
  logic i_ref_clk = 1'b0, i_rstn = 1'b0, von = 1'b0, dsr = 1'b0, strap = 1'b1;
  logic uv = 1'b0, ov = 1'b0, ocl = 1'b0, vup = 1'b0, vchg = 1'b0;
  logic pin, ab, ad, b200, swc, ce_out, ce_oe, pg, cpu, rup, tboot, hs, ls, dis, ana, rfree;
  logic uvm, fm, ocf, uvf, ovf;
  logic [1:0] rsel;
  int bad_count = 0, checks = 0, n;
  always #5 i_ref_clk = !i_ref_clk;
  core_regulator_power_sequencer #(.MODE_SAMPLE(MS), .BOOT_QUAL(BQ), .CPU_PG(CPG),
    .GFX_PG(GPG), .SLEEP_MASK(SM), .OC_TRIP(OCT)) core_regulator_power_sequencer_inst (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_regulator_on(von),
    .i_deep_sleep_request(dsr), .i_core_clock_enable_n(pin), .i_sense_above_boot(ab),
    .i_sense_above_dac(ad), .i_sense_below_200mv(b200), .i_undervoltage(uv),
    .i_overvoltage(ov), .i_over_current_limit(ocl), .i_switch_cycle(swc), .i_voltage_id_up(vup),
    .i_voltage_id_change(vchg), .o_core_clock_enable_n_out(ce_out),
    .o_core_clock_enable_n_oe(ce_oe),
    .o_power_good(pg), .o_cpu_mode(cpu), .o_ramp_current_sel(rsel), .o_ramp_up(rup),
    .o_target_boot(tboot), .o_high_side_gate_en(hs), .o_low_side_gate_en(ls),
    .o_discharge_en(dis), .o_analog_en(ana), .o_ring_free_mode(rfree),
    .o_undervoltage_mask(uvm), .o_fault_mask(fm), .o_overcurrent_fault(ocf),
    .o_undervoltage_fault(uvf), .o_overvoltage_fault(ovf));
  core_regulator_partner_model core_regulator_partner_model_inst (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_ramp_up(rup), .i_ramp_current_sel(rsel),
    .i_power_good(pg), .i_discharge_en(dis), .i_pin_out(ce_out), .i_pin_oe(ce_oe),
    .i_strap_high(strap), .o_pin_level(pin), .o_sense_above_boot(ab),
    .o_sense_above_dac(ad), .o_sense_below_200mv(b200), .o_switch_cycle(swc));
  // ==========================================================
  // Helpers
  function automatic logic sel(input int k);
    case (k)
      0: return pg;
      1: return ce_oe;
      2: return rup;
      3: return ab;
      4: return ad;
      5: return b200;
      default: return ocf;
    endcase
  endfunction
  task automatic wrap_up();
    $display("Counts: checks %0d, bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [1:0] seen, input logic [1:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic wait_on(input int k, input logic v, input int bound, output int c);
    c = 0;
    while (sel(k) !== v && c < bound) begin
      tick(1);
      c++;
    end
    if (sel(k) !== v) begin
      bad_count++;
      $display("Error wait %0d expected %b seen %b", k, v, sel(k));
      wrap_up();
    end
  endtask
  task automatic drive(input int k, input logic v);
    @(posedge i_ref_clk);
    case (k)
      0: von <= v;
      1: dsr <= v;
      2: uv <= v;
      3: ocl <= v;
      4: vchg <= v;
      5: vup <= v;
      default: ov <= v;
    endcase
    #1;
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    tick(10);
    @(posedge i_ref_clk) i_rstn <= 1'b1;
    tick(2);
    check("pg_reset", pg, 1'b0);
    // CPU power-up
    drive(0, 1'b1);
    wait_on(2, 1'b1, MS + 8, n);
    check("cpu_mode", cpu, 1'b1);
    check("target_boot", tboot, 1'b1);
    check("soft_start_sel", rsel, RAMP_20UA);
    drive(2, 1'b1);
    tick(6);
    check("uv_mask_low", uvm, 1'b1);
    drive(2, 1'b0);
    wait_on(3, 1'b1, 200, n);
    wait_on(1, 1'b1, BQ + 10, n);
    check("ce_pulled_low", {ce_oe, pin}, 2'h2);
    check("boot_qual", n >= BQ - 1 && n <= BQ + 8, 1'b1);
    check("pg_before", pg, 1'b0);
    wait_on(0, 1'b1, CPG + 6, n);
    check("cpu_pg_delay", n >= CPG - 2 && n <= CPG + 3, 1'b1);
    check("uv_fault", uvf, 1'b0);
    drive(4, 1'b1);
    tick(8);
    check("id_change_sel", rsel, RAMP_50UA);
    drive(4, 1'b0);
    // Deep sleep after power-good
    drive(1, 1'b1);
    drive(6, 1'b1);
    tick(6);
    check("ring_free_on", rfree, 1'b1);
    check("mask_on", fm, 1'b1);
    drive(6, 1'b0);
    tick(SM + 4);
    check("mask_off", fm, 1'b0);
    check("ov_masked", ovf, 1'b0);
    drive(1, 1'b0);
    tick(8);
    check("ring_free_off", rfree, 1'b0);
    // Current limit and latched trip
    drive(3, 1'b1);
    tick(6);
    check("hs_limited", hs, 1'b0);
    tick(8 * (OCT - 4));
    check("oc_early", ocf, 1'b0);
    wait_on(6, 1'b1, 8 * 8, n);
    tick(2);
    check("oc_gates", {hs, ls}, 2'h0);
    check("oc_discharge", dis, 1'b1);
    drive(3, 1'b0);
    tick(30);
    check("oc_latched", ocf, 1'b1);
    drive(0, 1'b0);
    tick(12);
    drive(0, 1'b1);
    tick(8);
    check("oc_cleared", ocf, 1'b0);
    wait_on(0, 1'b1, 400, n);
    // Power down
    drive(0, 1'b0);
    wait_on(0, 1'b0, 8, n);
    tick(1);
    check("down_sel", rsel, RAMP_20UA);
    check("down_ramp", rup, 1'b0);
    wait_on(5, 1'b1, 200, n);
    tick(8);
    check("off_gates", {hs, ls}, 2'h0);
    check("off_dis_ana", {dis, ana}, 2'h2);
    // Render power-up with an early sleep request
    @(posedge i_ref_clk) strap <= 1'b0;
    drive(1, 1'b1);
    drive(0, 1'b1);
    wait_on(2, 1'b1, MS + 8, n);
    check("render_mode", {cpu, tboot}, 2'h0);
    check("render_sel", rsel, RAMP_20UA);
    wait_on(4, 1'b1, 200, n);
    check("ring_free_ignored", rfree, 1'b0);
    wait_on(0, 1'b1, GPG + 10, n);
    check("gfx_pg_delay", n >= GPG - 1 && n <= GPG + 8, 1'b1);
    tick(6);
    check("render_ring_free", rfree, 1'b1);
    drive(5, 1'b1);
    drive(4, 1'b1);
    tick(8);
    check("ring_free_up_sel", rsel, RAMP_100UA);
    drive(5, 1'b0);
    tick(8);
    check("ring_free_chg_sel", rsel, RAMP_50UA);
    drive(4, 1'b0);
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
